// ==== hdl/opt_cfg_pkg.sv ====
// constants, field layout and types for the option byte configuration loader
package opt_cfg_pkg;

  // ----------------------------------------------------------------
  // option storage
  // ----------------------------------------------------------------
  localparam logic [7:0] OPT_ERASED = 8'hff;
  // byte 0 fields
  localparam int HALT_RST_BIT = 7;
  localparam int WATCHDOG_SOFTWARE_SELECT_BIT = 6;
  localparam int CLK_SRC_BIT = 5;
  localparam int DET_HI_BIT = 4;
  localparam int DET_LO_BIT = 3;
  localparam int RST_DLY_BIT = 2;
  localparam int HALVE_BIT = 1;
  localparam int PROT_BIT = 0;
  // byte 1 fields
  localparam int PKG_HI_BIT = 7;
  localparam int PKG_LO_BIT = 5;
  localparam int MOTOR_HI_BIT = 1;
  localparam int MOTOR_LO_BIT = 0;

  // ----------------------------------------------------------------
  // timing, in cpu cycles
  // ----------------------------------------------------------------
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] LONG_DELAY_CYC = 13'h1000;
  localparam logic [CNT_W-1:0] SHORT_DELAY_CYC = 13'h0100;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_OPT0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OPT1 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
  localparam int CMD_ERASE_BIT = 0;
  localparam int ST_RESET_BIT = 0;
  localparam int ST_ERASE_BIT = 1;
  localparam int ST_PROG_BIT = 2;
  localparam int ST_PROT_BIT = 3;
  localparam int ST_STALL_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // package pin counts
  // ----------------------------------------------------------------
  localparam logic [6:0] PINS_32 = 7'h20;
  localparam logic [6:0] PINS_44 = 7'h2c;
  localparam logic [6:0] PINS_56 = 7'h38;
  localparam logic [6:0] PINS_64 = 7'h40;
  localparam logic [6:0] PINS_80 = 7'h50;

  // gray along load -> hold -> run
  typedef enum logic [1:0] {
    SEQ_LOAD = 2'h0,
    SEQ_HOLD = 2'h1,
    SEQ_RUN = 2'h3
  } seq_t;

endpackage

// ==== hdl/option_byte_config.sv ====
// option byte storage, reset-time capture, reset sequencing and axi4-lite access
//
// Summary of operation
// - erased option storage reads all ones
// - option bytes reachable only in programming mode
// - halt with watchdog running and byte0 bit7 set forces reset
// - byte0 bit6 low forces watchdog always on
// - byte0 bit5 chooses pll or oscillator clock
// - byte0 bits4:3 enable low-voltage and auxiliary detectors
// - byte0 bit2 picks 4096 or 256 cycle delay
// - pll clock selection forces 4096 cycle delay
// - byte0 bit1 low enables input divide by two
// - protect bit low blocks test/icp memory access
// - protected erase wipes user memory first
// - byte1 bits7:5 name the package variant
// - byte1 bits1:0 set motor outputs during reset
module option_byte_config
  import opt_cfg_pkg::*;
(
  // clock and resets
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic PWR_ON_RST,
  // mode pins, asynchronous
  input wire logic PROG_MODE,
  input wire logic ICP_MODE,
  input wire logic TEST_MODE,
  // core events, same clock
  input wire logic HALT_ENTER,
  input wire logic HALT_WAKE,
  input wire logic WDG_RUNNING,
  input wire logic MEM_ERASE_DONE,
  // axi4-lite write
  input wire logic [opt_cfg_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [opt_cfg_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // configuration outputs
  output logic CORE_STALL,
  output logic HALT_RESET_PULSE,
  output logic WDG_HW_ON,
  output logic CLK_OSC_SEL,
  output logic HALVE_EN,
  output logic LVD_EN,
  output logic AVD_EN,
  output logic MEM_ACCESS_BLOCK,
  output logic MEM_ERASE_REQ,
  output logic [2:0] PACKAGE_VARIANT,
  output logic [6:0] PACKAGE_PINS,
  output logic MOTOR_OUT_VAL,
  output logic MOTOR_OUT_OE
);
  import opt_cfg_pkg::*;

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  // pll selection overrides the short delay, value is count minus one
  function automatic logic [CNT_W-1:0] delay_load(input logic [7:0] b0);
    logic long_dly;
    long_dly = !b0[CLK_SRC_BIT] || !b0[RST_DLY_BIT];
    delay_load = (long_dly ? LONG_DELAY_CYC : SHORT_DELAY_CYC) - 13'h0001;
  endfunction

  function automatic logic [6:0] pins_of(input logic [2:0] code);
    casez (code)
      3'b1??: pins_of = PINS_80;
      3'b011: pins_of = PINS_64;
      3'b010: pins_of = PINS_56;
      3'b001: pins_of = PINS_44;
      default: pins_of = PINS_32;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] nv0;
    logic [7:0] nv1;
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    seq_t seq;
    logic [CNT_W-1:0] cnt;
    logic rst_phase;
    logic [1:0] prog_s;
    logic [1:0] icp_s;
    logic [1:0] test_s;
    logic erase_busy;
    logic erase_req;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic stall;
    logic halt_rst;
    logic wdg_hw;
    logic clk_osc;
    logic halve;
    logic low_voltage_reset_detector;
    logic auxiliary_voltage_detector;
    logic mem_block;
    logic [2:0] pkg;
    logic [6:0] pins;
    logic motor_val;
    logic motor_oe;
  } state_t;

  state_t q_reg;
  state_t q_next;
  logic prog_on;
  logic [31:0] status_word;

  assign prog_on = q_reg.prog_s[1];
  assign status_word = {27'h0000000, q_reg.stall, !q_reg.cfg0[PROT_BIT], prog_on,
                        q_reg.erase_busy, q_reg.rst_phase};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    q_next.prog_s = {q_reg.prog_s[0], PROG_MODE};
    q_next.icp_s = {q_reg.icp_s[0], ICP_MODE};
    q_next.test_s = {q_reg.test_s[0], TEST_MODE};
    q_next.halt_rst = 1'b0;

    // reset sequencing
    case (q_reg.seq)
      SEQ_LOAD: begin
        q_next.cfg0 = q_reg.nv0;
        q_next.cfg1 = q_reg.nv1;
        q_next.cnt = delay_load(q_reg.nv0);
        q_next.seq = SEQ_HOLD;
      end
      SEQ_HOLD: begin
        if (q_reg.cnt == '0) begin
          q_next.seq = SEQ_RUN;
          q_next.rst_phase = 1'b0;
        end else begin
          q_next.cnt = q_reg.cnt - 13'h0001;
        end
      end
      SEQ_RUN: begin
        if (HALT_ENTER && WDG_RUNNING && q_reg.cfg0[HALT_RST_BIT]) begin
          q_next.halt_rst = 1'b1;
          q_next.seq = SEQ_LOAD;
          q_next.rst_phase = 1'b1;
        end else if (HALT_WAKE) begin
          // wake delay uses the same length as the reset phase
          q_next.cnt = delay_load(q_reg.cfg0);
          q_next.seq = SEQ_HOLD;
        end
      end
      default: begin
        q_next.seq = SEQ_LOAD;
        q_next.rst_phase = 1'b1;
      end
    endcase

    // erase: user memory goes first when protection is set
    if (q_reg.erase_busy && MEM_ERASE_DONE) begin
      q_next.erase_busy = 1'b0;
      q_next.erase_req = 1'b0;
      q_next.nv0 = OPT_ERASED;
      q_next.nv1 = OPT_ERASED;
    end

    // write channel: address and data taken in either order
    if (AWVALID && q_reg.awready) begin
      q_next.aw_got = 1'b1;
      q_next.awaddr = AWADDR;
    end
    if (WVALID && q_reg.wready) begin
      q_next.w_got = 1'b1;
      q_next.wdata = WDATA;
      q_next.wstrb = WSTRB;
    end
    if (q_reg.bvalid && BREADY) begin
      q_next.bvalid = 1'b0;
    end
    if (q_reg.aw_got && q_reg.w_got && !q_reg.bvalid) begin
      q_next.aw_got = 1'b0;
      q_next.w_got = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp = RESP_SLVERR;
      // option storage is invisible outside programming mode
      if (prog_on && !q_reg.erase_busy) begin
        case (q_reg.awaddr)
          ADDR_OPT0: begin
            q_next.bresp = RESP_OKAY;
            if (q_reg.wstrb[0]) begin
              q_next.nv0 = q_reg.wdata[7:0];
            end
          end
          ADDR_OPT1: begin
            q_next.bresp = RESP_OKAY;
            if (q_reg.wstrb[0]) begin
              q_next.nv1 = q_reg.wdata[7:0];
            end
          end
          ADDR_CMD: begin
            q_next.bresp = RESP_OKAY;
            if (q_reg.wstrb[0] && q_reg.wdata[CMD_ERASE_BIT]) begin
              if (!q_reg.nv0[PROT_BIT]) begin
                q_next.erase_busy = 1'b1;
                q_next.erase_req = 1'b1;
              end else begin
                q_next.nv0 = OPT_ERASED;
                q_next.nv1 = OPT_ERASED;
              end
            end
          end
          default: q_next.bresp = RESP_SLVERR;
        endcase
      end
    end
    q_next.awready = !q_next.aw_got && !q_next.bvalid;
    q_next.wready = !q_next.w_got && !q_next.bvalid;

    // read channel
    if (q_reg.rvalid && RREADY) begin
      q_next.rvalid = 1'b0;
    end
    if (ARVALID && q_reg.arready) begin
      q_next.rvalid = 1'b1;
      q_next.rdata = 32'h00000000;
      q_next.rresp = RESP_SLVERR;
      if (ARADDR == ADDR_STATUS) begin
        q_next.rdata = status_word;
        q_next.rresp = RESP_OKAY;
      end else if (prog_on && ARADDR == ADDR_OPT0) begin
        q_next.rdata = {24'h000000, q_reg.nv0};
        q_next.rresp = RESP_OKAY;
      end else if (prog_on && ARADDR == ADDR_OPT1) begin
        q_next.rdata = {24'h000000, q_reg.nv1};
        q_next.rresp = RESP_OKAY;
      end else if (prog_on && ARADDR == ADDR_CMD) begin
        q_next.rresp = RESP_OKAY;
      end
    end
    q_next.arready = !q_next.rvalid;

    // outputs follow the captured bytes, never the storage
    q_next.stall = q_next.seq != SEQ_RUN;
    q_next.wdg_hw = !q_next.cfg0[WATCHDOG_SOFTWARE_SELECT_BIT];
    q_next.clk_osc = q_next.cfg0[CLK_SRC_BIT];
    q_next.halve = !q_next.cfg0[HALVE_BIT];
    // only code 10 switches both detectors off
    q_next.low_voltage_reset_detector = q_next.cfg0[DET_HI_BIT:DET_LO_BIT] != 2'h2;
    q_next.auxiliary_voltage_detector = q_next.cfg0[DET_HI_BIT] == q_next.cfg0[DET_LO_BIT];
    // only the second sync stage may feed logic
    q_next.mem_block = !q_next.cfg0[PROT_BIT] &&
                       (q_reg.icp_s[1] || q_reg.test_s[1]);
    q_next.pkg = q_next.cfg1[PKG_HI_BIT:PKG_LO_BIT];
    q_next.pins = pins_of(q_next.cfg1[PKG_HI_BIT:PKG_LO_BIT]);
    // 00 and 11 leave the motor pins floating
    q_next.motor_oe = q_next.rst_phase &&
                      (q_next.cfg1[MOTOR_HI_BIT] ^ q_next.cfg1[MOTOR_LO_BIT]);
    q_next.motor_val = q_next.cfg1[MOTOR_HI_BIT];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (PWR_ON_RST || SRST) begin
      q_reg <= '0;
      // storage survives a plain reset, a power-on reset erases it
      q_reg.nv0 <= PWR_ON_RST ? OPT_ERASED : q_reg.nv0;
      q_reg.nv1 <= PWR_ON_RST ? OPT_ERASED : q_reg.nv1;
      q_reg.cfg0 <= OPT_ERASED;
      q_reg.cfg1 <= OPT_ERASED;
      q_reg.seq <= SEQ_LOAD;
      q_reg.rst_phase <= 1'b1;
      q_reg.stall <= 1'b1;
      q_reg.clk_osc <= 1'b1;
      q_reg.low_voltage_reset_detector <= 1'b1;
      q_reg.auxiliary_voltage_detector <= 1'b1;
      q_reg.pkg <= 3'h7;
      q_reg.pins <= PINS_80;
      q_reg.motor_val <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign AWREADY = q_reg.awready;
  assign WREADY = q_reg.wready;
  assign BVALID = q_reg.bvalid;
  assign BRESP = q_reg.bresp;
  assign ARREADY = q_reg.arready;
  assign RVALID = q_reg.rvalid;
  assign RDATA = q_reg.rdata;
  assign RRESP = q_reg.rresp;
  assign CORE_STALL = q_reg.stall;
  assign HALT_RESET_PULSE = q_reg.halt_rst;
  assign WDG_HW_ON = q_reg.wdg_hw;
  assign CLK_OSC_SEL = q_reg.clk_osc;
  assign HALVE_EN = q_reg.halve;
  assign LVD_EN = q_reg.low_voltage_reset_detector;
  assign AVD_EN = q_reg.auxiliary_voltage_detector;
  assign MEM_ACCESS_BLOCK = q_reg.mem_block;
  assign MEM_ERASE_REQ = q_reg.erase_req;
  assign PACKAGE_VARIANT = q_reg.pkg;
  assign PACKAGE_PINS = q_reg.pins;
  assign MOTOR_OUT_VAL = q_reg.motor_val;
  assign MOTOR_OUT_OE = q_reg.motor_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_erased_default: assert property (@(posedge CORE_CLK)
    $past(PWR_ON_RST) |-> q_reg.nv0 == OPT_ERASED && q_reg.nv1 == OPT_ERASED)
    else $error("storage not erased after power-on");
  a_opt_hidden: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    ARVALID && ARREADY && !prog_on && ARADDR == ADDR_OPT0
    |=> RVALID && RRESP == RESP_SLVERR && RDATA == 32'h00000000)
    else $error("option byte visible outside programming mode");
  a_halt_reset: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_RUN && HALT_ENTER && WDG_RUNNING
    |=> HALT_RESET_PULSE == $past(q_reg.cfg0[HALT_RST_BIT]) ##1 !HALT_RESET_PULSE)
    else $error("halt reset wrong");
  a_watchdog_type: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_LOAD |=> WDG_HW_ON == !$past(q_reg.nv0[WATCHDOG_SOFTWARE_SELECT_BIT]))
    else $error("watchdog type not taken from storage");
  a_clock_source: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_LOAD |=> CLK_OSC_SEL == $past(q_reg.nv0[CLK_SRC_BIT]))
    else $error("clock source not taken from storage");
  a_detector_off: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_HOLD
    |-> LVD_EN == (q_reg.cfg0[DET_HI_BIT:DET_LO_BIT] != 2'h2)
    && AVD_EN == (q_reg.cfg0[DET_HI_BIT:DET_LO_BIT] == 2'h0 ||
                  q_reg.cfg0[DET_HI_BIT:DET_LO_BIT] == 2'h3))
    else $error("detector enables wrong");
  a_delay_length: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_HOLD && $past(q_reg.seq) == SEQ_LOAD && q_reg.cfg0[CLK_SRC_BIT]
    && q_reg.cfg0[RST_DLY_BIT] |-> q_reg.cnt == 13'h00ff)
    else $error("short delay count wrong");
  a_pll_forces_long: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_HOLD && $past(q_reg.seq) == SEQ_LOAD && !q_reg.cfg0[CLK_SRC_BIT]
    |-> q_reg.cnt == 13'h0fff)
    else $error("pll selection did not force long delay");
  a_halve_select: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_LOAD |=> HALVE_EN == !$past(q_reg.nv0[HALVE_BIT]))
    else $error("divider select wrong");
  a_readout_block: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.cfg0[PROT_BIT] |-> !MEM_ACCESS_BLOCK)
    else $error("memory blocked without protection");
  a_erase_first: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    MEM_ERASE_REQ && !MEM_ERASE_DONE |=> q_reg.nv0 == $past(q_reg.nv0))
    else $error("option bytes changed before memory erase");
  a_package_code: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    PACKAGE_VARIANT[2] |-> PACKAGE_PINS == PINS_80)
    else $error("package pin count wrong");
  a_motor_reset: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    MOTOR_OUT_OE |-> q_reg.rst_phase && MOTOR_OUT_VAL == q_reg.cfg1[MOTOR_HI_BIT])
    else $error("motor outputs driven outside reset");
  a_config_static: assert property (@(posedge CORE_CLK) disable iff (SRST || PWR_ON_RST)
    q_reg.seq == SEQ_RUN ##1 q_reg.seq == SEQ_RUN |-> $stable(q_reg.cfg0) && $stable(q_reg.cfg1))
    else $error("configuration changed while running");

endmodule

// ==== tb/prog_tool.sv ====
// programming tool model: axi4-lite master reaching the option storage
module prog_tool
  import opt_cfg_pkg::*;
(
  // clock
  input wire logic CORE_CLK,
  // write channels
  output logic [opt_cfg_pkg::ADDR_W-1:0] AWADDR = 8'h0,
  output logic AWVALID = 1'h0,
  input wire logic AWREADY,
  output logic [31:0] WDATA = 32'h0,
  output logic [3:0] WSTRB = 4'h0,
  output logic WVALID = 1'h0,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  output logic BREADY = 1'h0,
  // read channels
  output logic [opt_cfg_pkg::ADDR_W-1:0] ARADDR = 8'h0,
  output logic ARVALID = 1'h0,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  output logic RREADY = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung = 1'h0;

  // released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    AWADDR <= a;
    AWVALID <= 1'h1;
    WDATA <= d;
    WSTRB <= 4'hf;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do begin
      @(posedge CORE_CLK);
      n++;
      if (AWVALID && AWREADY) begin
        AWVALID <= 1'h0;
        AWADDR <= ~a;
      end
      if (WVALID && WREADY) begin
        WVALID <= 1'h0;
        WDATA <= ~d;
      end
    end while (!BVALID && n < 200);
    hung |= (n >= 200);
    r = BRESP;
    BREADY <= 1'h0;
    // one edge between transfers so no line is driven twice in a step
    @(posedge CORE_CLK);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do begin
      @(posedge CORE_CLK);
      n++;
      if (ARVALID && ARREADY) begin
        ARVALID <= 1'h0;
        ARADDR <= ~a;
      end
    end while (!RVALID && n < 200);
    hung |= (n >= 200);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'h0;
    @(posedge CORE_CLK);
  endtask
endmodule

// ==== tb/tb.sv ====
// bench for the option byte configuration loader
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import opt_cfg_pkg::*;
  localparam logic [7:0] T0 [5] = '{8'hff, 8'he7, 8'hcf, 8'h31, 8'hfe};
  localparam logic [7:0] T1 [5] = '{8'h01, 8'h22, 8'h40, 8'h63, 8'ha3};
  logic CORE_CLK = 1'h0;
  logic SRST = 1'h1;
  logic PWR_ON_RST = 1'h1;
  logic PROG_MODE = 1'h0;
  logic ICP_MODE = 1'h0;
  logic TEST_MODE = 1'h0;
  logic HALT_ENTER = 1'h0;
  logic HALT_WAKE = 1'h0;
  logic WDG_RUNNING = 1'h0;
  logic MEM_ERASE_DONE = 1'h0;
  logic [ADDR_W-1:0] AWADDR, ARADDR;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic CORE_STALL, HALT_RESET_PULSE, WDG_HW_ON, CLK_OSC_SEL, HALVE_EN, LVD_EN, AVD_EN;
  logic MEM_ACCESS_BLOCK, MEM_ERASE_REQ, MOTOR_OUT_VAL, MOTOR_OUT_OE;
  logic [2:0] PACKAGE_VARIANT;
  logic [6:0] PACKAGE_PINS;
  wire logic [11:0] live = {WDG_HW_ON, CLK_OSC_SEL, HALVE_EN, LVD_EN, AVD_EN, PACKAGE_PINS};
  int err_count = 0;
  int cmp_count = 0;

  always #12.5 CORE_CLK = ~CORE_CLK;

  option_byte_config DUT (.CORE_CLK, .SRST, .PWR_ON_RST, .PROG_MODE, .ICP_MODE, .TEST_MODE,
    .HALT_ENTER, .HALT_WAKE, .WDG_RUNNING, .MEM_ERASE_DONE, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY, .CORE_STALL, .HALT_RESET_PULSE, .WDG_HW_ON,
    .CLK_OSC_SEL, .HALVE_EN, .LVD_EN, .AVD_EN, .MEM_ACCESS_BLOCK, .MEM_ERASE_REQ,
    .PACKAGE_VARIANT, .PACKAGE_PINS, .MOTOR_OUT_VAL, .MOTOR_OUT_OE);

  prog_tool tool (.CORE_CLK, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("wrong value wait exp done got timeout");
    wrap_up();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    tool.wr(a, {24'h0, d}, r);
    if (tool.hung) hang();
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    tool.rd(a, d, r);
    if (tool.hung) hang();
    chk("rresp", 32'(er), 32'(r));
    chk("rdata", 32'(ed), d);
  endtask

  // every caller starts polling one hold cycle in, so n-1 remain
  task automatic stall_len(input int n);
    int c;
    c = 0;
    while (CORE_STALL === 1'h1 && c < 5000) begin
      @(posedge CORE_CLK);
      c++;
    end
    if (c >= 5000) hang();
    cmp_count++;
    if (c != n - 1) begin
      err_count++;
      $display("wrong value stall exp %0d got %0d", n, c);
    end
  endtask

  task automatic halt_try(input logic e);
    logic seen;
    HALT_ENTER <= 1'h1;
    seen = 1'h0;
    repeat (4) begin
      @(posedge CORE_CLK);
      HALT_ENTER <= 1'h0;
      seen |= HALT_RESET_PULSE;
    end
    chk("halt_rst", 32'(e), 32'(seen));
  endtask

  function automatic logic [11:0] cfg(input logic [7:0] o0, input logic [7:0] o1);
    logic [6:0] p;
    case (o1[7:5])
      3'h0: p = 7'h20;
      3'h1: p = 7'h2c;
      3'h2: p = 7'h38;
      3'h3: p = 7'h40;
      default: p = 7'h50;
    endcase
    return {~o0[6], o0[5], ~o0[1], o0[4:3] != 2'h2, o0[4] == o0[3], p};
  endfunction

  task automatic settle(input logic [7:0] o0, input logic [7:0] o1);
    logic oe;
    oe = ^o1[1:0];
    cyc(3);
    chk("motor", 32'({oe, oe & o1[1]}), 32'({MOTOR_OUT_OE, oe & MOTOR_OUT_VAL}));
    chk("cfg", 32'(cfg(o0, o1)), 32'(live));
    chk("pkg", 32'(o1[7:5]), 32'(PACKAGE_VARIANT));
    stall_len((o0[5] & o0[2]) ? 256 : 4096);
    chk("motor_off", 32'h0, 32'(MOTOR_OUT_OE));
  endtask

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    repeat (100000) @(posedge CORE_CLK);
    hang();
  end

  initial begin
    int n;
    cyc(10);
    SRST <= 1'h0;
    PWR_ON_RST <= 1'h0;
    settle(8'hff, 8'hff);
    rd(ADDR_OPT0, 8'h0, RESP_SLVERR);
    wr(ADDR_OPT0, 8'h0, RESP_SLVERR);
    rd(8'h10, 8'h0, RESP_SLVERR);
    // halt with the watchdog stopped must not reset
    halt_try(1'h0);
    PROG_MODE <= 1'h1;
    WDG_RUNNING <= 1'h1;
    cyc(4);
    for (int i = 0; i < 5; i++) begin
      n = (T0[i][5] & T0[i][2]) ? 256 : 4096;
      wr(ADDR_OPT0, T0[i], RESP_OKAY);
      wr(ADDR_OPT1, T1[i], RESP_OKAY);
      rd(ADDR_OPT0, T0[i], RESP_OKAY);
      chk("held", 32'(i == 0 ? cfg(8'hff, 8'hff) : cfg(T0[i-1], T1[i-1])), 32'(live));
      SRST <= 1'h1;
      cyc(10);
      SRST <= 1'h0;
      settle(T0[i], T1[i]);
      HALT_WAKE <= 1'h1;
      cyc(1);
      HALT_WAKE <= 1'h0;
      cyc(2);
      stall_len(n);
      halt_try(T0[i][7]);
      if (T0[i][7]) stall_len(n);
    end
    ICP_MODE <= 1'h1;
    cyc(4);
    chk("blk_icp", 32'h1, 32'(MEM_ACCESS_BLOCK));
    ICP_MODE <= 1'h0;
    TEST_MODE <= 1'h1;
    cyc(4);
    chk("blk_test", 32'h1, 32'(MEM_ACCESS_BLOCK));
    TEST_MODE <= 1'h0;
    cyc(4);
    chk("blk_off", 32'h0, 32'(MEM_ACCESS_BLOCK));
    wr(ADDR_CMD, 8'h01, RESP_OKAY);
    cyc(3);
    chk("erase_req", 32'h1, 32'(MEM_ERASE_REQ));
    wr(ADDR_OPT1, 8'h00, RESP_SLVERR);
    rd(ADDR_STATUS, 8'h0e, RESP_OKAY);
    rd(ADDR_OPT0, 8'hfe, RESP_OKAY);
    MEM_ERASE_DONE <= 1'h1;
    cyc(1);
    MEM_ERASE_DONE <= 1'h0;
    cyc(3);
    chk("erase_req", 32'h0, 32'(MEM_ERASE_REQ));
    rd(ADDR_OPT0, 8'hff, RESP_OKAY);
    rd(ADDR_OPT1, 8'hff, RESP_OKAY);
    // unprotected storage erases at once, no memory erase asked
    wr(ADDR_OPT0, 8'h5b, RESP_OKAY);
    wr(ADDR_CMD, 8'h01, RESP_OKAY);
    chk("erase_req", 32'h0, 32'(MEM_ERASE_REQ));
    rd(ADDR_OPT0, 8'hff, RESP_OKAY);
    wrap_up();
  end
endmodule
